// File: logic/fpt_map.svh
// Register offsets, field positions, reset values and timing counts of the fan controller.
`ifndef FPT_MAP_SVH
`define FPT_MAP_SVH
`define FPT_CLK_HZ          20000000
`define FPT_PWM_HZ          18
`define FPT_WIN_MS          125
`define FPT_GAP_MS          500
`define FPT_DUTY_FULL       8'h64
// Cycles per duty step: one PWM period split into 100 steps.
`define FPT_PWM_STEP_CYC    ((`FPT_CLK_HZ / `FPT_PWM_HZ) / 100)
`define FPT_WIN_CYC         ((`FPT_CLK_HZ / 1000) * `FPT_WIN_MS)
`define FPT_GAP_CYC         ((`FPT_CLK_HZ / 1000) * `FPT_GAP_MS)
`define FPT_OFF_DUTY0       8'h00
`define FPT_OFF_DUTY1       8'h04
`define FPT_OFF_DUTY2       8'h08
`define FPT_OFF_DUTY3       8'h0c
`define FPT_OFF_CFG         8'h10
`define FPT_OFF_GLITCH      8'h14
`define FPT_OFF_FSTIME      8'h18
`define FPT_OFF_TACH0       8'h20
`define FPT_OFF_TACH1       8'h24
`define FPT_OFF_TACH2       8'h28
`define FPT_OFF_TACH3       8'h2c
`define FPT_OFF_IRQ_STAT    8'h30
`define FPT_OFF_IRQ_EN      8'h34
`define FPT_OFF_IRQ_CLR     8'h38
`define FPT_OFF_BOOT        8'h3c
`define FPT_CFG_REP_LSB     0
`define FPT_CFG_FS_LSB      4
`define FPT_CFG_PPR_LSB     8
`define FPT_GLITCH_RST      16'h0000
`define FPT_FSTIME_RST      32'h0000_0000
`define FPT_BAD_READ        32'h0000_0000
`endif

// File: logic/fpt_pkg.sv
// Types shared by the fan controller files.
package fpt_pkg;
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } fpt_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } fpt_rsp_t;
   typedef enum logic [1:0] {
      FPT_ST_RUN  = 2'b00,
      FPT_ST_WIN  = 2'b01,
      FPT_ST_HOLD = 2'b10
   } fpt_meas_t;
endpackage

// File: logic/fpt_result_mem.sv
// Small memory of per-fan tachometer results with registered read data.
`timescale 1ns/100ps
module fpt_result_mem #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 32
) (
   input  wire logic                     REF_CLK,
   input  wire logic                     RST_B,
   input  wire logic                     WR_EN,
   input  wire logic [$clog2(DEPTH)-1:0] WR_ADDR,
   input  wire logic [WIDTH-1:0]         WR_DATA,
   input  wire logic [$clog2(DEPTH)-1:0] RD_ADDR,
   output logic      [WIDTH-1:0]         RD_DATA
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rd;
   } fpt_mem_state_t;
   fpt_mem_state_t s_r;
   fpt_mem_state_t s_nxt;
   always_comb begin
      s_nxt = s_r;
      if (WR_EN) begin
         s_nxt.mem[WR_ADDR] = WR_DATA;
      end
      s_nxt.rd = s_r.mem[RD_ADDR];
   end
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign RD_DATA = s_r.rd;
endmodule // fpt_result_mem

// File: logic/fpt_pwm.sv
// One fan channel: duty-cycle PWM driving an open-drain low-side switch.
`timescale 1ns/100ps
module fpt_pwm (
   input  wire logic       REF_CLK,
   input  wire logic       RST_B,
   input  wire logic [6:0] PHASE,
   input  wire logic [7:0] DUTY,
   input  wire logic       FORCE_ON,
   input  wire logic       ENABLE,
   output logic            SW_OE
);
   typedef struct packed {
      logic oe;
   } fpt_pwm_state_t;
   fpt_pwm_state_t s_r;
   fpt_pwm_state_t s_nxt;
   always_comb begin
      s_nxt = s_r;
      // duty compare
      // Switch closed (pin driven low) while enabled and either forced on or phase is below the duty figure.
      s_nxt.oe = ENABLE && (FORCE_ON || ({1'b0, PHASE} < DUTY));
   end
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign SW_OE = s_r.oe;
endmodule // fpt_pwm

// File: logic/fpt_top.sv
// Fan power PWM and tachometer monitor with an Avalon-MM register slave.
`timescale 1ns/100ps
`include "fpt_map.svh"
module fpt_top #(
   parameter int NFAN    = 4,
   parameter int WIN_CYC = `FPT_WIN_CYC,
   parameter int GAP_CYC = `FPT_GAP_CYC
) (
   input  wire logic               REF_CLK,
   input  wire logic               RST_B,
   input  wire fpt_pkg::fpt_req_t  AVS_REQ,
   output fpt_pkg::fpt_rsp_t       AVS_RSP,
   input  wire logic [NFAN-1:0]    FAN_TACH,
   input  wire logic [NFAN-1:0]    BOOT_VALID,
   output logic      [NFAN-1:0]    FAN_SW_O,
   output logic      [NFAN-1:0]    FAN_SW_OE,
   output logic                    IRQ
);
   import fpt_pkg::*;
   localparam int STEP_CYC = `FPT_PWM_STEP_CYC;
   localparam int FW = $clog2(NFAN);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NFAN-1:0][7:0]  duty;
      logic [NFAN-1:0][7:0]  boot;
      logic [NFAN-1:0]       rep_en;
      logic [NFAN-1:0]       fs_en;
      logic [NFAN-1:0][1:0]  ppr;
      logic [15:0]           glitch;
      logic [31:0]           fs_time;
      logic [31:0]           fs_cnt;
      logic [NFAN-1:0]       fs_trip;
      logic [15:0]           step;
      logic [6:0]            phase;
      fpt_meas_t             meas;
      logic [FW-1:0]         fan;
      logic [31:0]           win;
      logic [15:0]           gl_cnt;
      logic [1:0]            edges;
      logic [23:0]           count;
      logic                  tach_d;
      logic [NFAN-1:0]       started;
      logic [31:0]           start_cnt;
      logic [NFAN-1:0]       irq_stat;
      logic [NFAN-1:0]       irq_en;
      logic                  rd_pend;
      logic                  rd_mem;
      logic [31:0]           rdata;
      logic                  init;
   } fpt_state_t;
   fpt_state_t s_r;
   fpt_state_t s_nxt;

   logic            res_wr;
   logic [31:0]     res_wdata;
   logic [31:0]     mem_rdata;
   logic [FW-1:0]   mem_raddr;
   logic [NFAN-1:0] force_on;
   logic [NFAN-1:0][7:0] eff_duty;

   function automatic logic [31:0] fpt_lane(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] fpt_clamp(input logic [7:0] d);
      return (d > `FPT_DUTY_FULL) ? `FPT_DUTY_FULL : d;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] wv;
      logic        tach_edge;
      logic        duty_wr;
      s_nxt     = s_r;
      wv        = '0;
      duty_wr   = 1'b0;
      res_wr    = 1'b0;
      res_wdata = '0;
      tach_edge = 1'b0;

      // boot duty load
      // The boot value is sampled one cycle after reset release, never in reset.
      if (s_r.init) begin
         s_nxt.init = 1'b0;
         for (int i = 0; i < NFAN; i++) begin
            if (BOOT_VALID[i]) begin
               s_nxt.duty[i] = fpt_clamp(s_r.boot[i]);
            end else begin
               s_nxt.duty[i] = `FPT_DUTY_FULL;
            end
         end
      end

      if (s_r.step == 16'(STEP_CYC - 1)) begin
         s_nxt.step  = '0;
         s_nxt.phase = (s_r.phase == 7'(`FPT_DUTY_FULL - 1)) ? '0 : s_r.phase + 7'h01;
      end else begin
         s_nxt.step = s_r.step + 16'h0001;
      end

      // staggered start
      // Limits the inrush on the fan supply; each fan waits its turn in index order.
      if (s_r.started != '1) begin
         if (s_r.start_cnt == 32'(GAP_CYC - 1) || s_r.started == '0) begin
            s_nxt.start_cnt = '0;
            for (int i = NFAN - 1; i >= 0; i--) begin
               if (!s_r.started[i] && (i == 0 || s_r.started[i-1])) begin
                  s_nxt.started[i] = 1'b1;
               end
            end
         end else begin
            s_nxt.start_cnt = s_r.start_cnt + 32'h1;
         end
      end

      s_nxt.tach_d = FAN_TACH[s_r.fan];
      tach_edge    = FAN_TACH[s_r.fan] && !s_r.tach_d;

      s_nxt.win = s_r.win + 32'h1;
      case (s_r.meas)
         FPT_ST_RUN: begin
            s_nxt.meas   = FPT_ST_WIN;
            s_nxt.win    = '0;
            s_nxt.count  = '0;
            s_nxt.gl_cnt = '0;
            s_nxt.edges  = '0;
         end
         FPT_ST_WIN: begin
            if (s_r.gl_cnt != s_r.glitch) begin
               s_nxt.gl_cnt = s_r.gl_cnt + 16'h0001;
            end else if (tach_edge) begin
               s_nxt.gl_cnt = '0;
               s_nxt.count  = s_r.count + 24'h000001;
               if (s_r.edges != 2'b10) begin
                  s_nxt.edges = s_r.edges + 2'b01;
               end
            end
            if (s_r.win == 32'(WIN_CYC - 1)) begin
               s_nxt.meas = FPT_ST_HOLD;
               res_wr     = 1'b1;
               res_wdata  = {6'h00, s_r.ppr[s_r.fan], s_r.count};
               if (s_r.rep_en[s_r.fan]) begin
                  s_nxt.irq_stat[s_r.fan] = 1'b1;
               end
            end
         end
         FPT_ST_HOLD: begin
            // next fan every quarter of the half-second cycle
            // The window may fill the whole slot, so the end test must not be an equality.
            if (s_r.win >= 32'(GAP_CYC / NFAN - 2)) begin
               s_nxt.meas = FPT_ST_RUN;
               s_nxt.fan  = (s_r.fan == FW'(NFAN - 1)) ? '0 : s_r.fan + FW'(1);
            end
         end
         default: begin
            s_nxt.meas = FPT_ST_RUN;
         end
      endcase

      if (s_r.fs_time != '0 && s_r.fs_cnt != s_r.fs_time) begin
         s_nxt.fs_cnt = s_r.fs_cnt + 32'h1;
      end
      if (s_r.fs_time != '0 && s_r.fs_cnt == s_r.fs_time) begin
         s_nxt.fs_trip = s_r.fs_trip | s_r.fs_en;
      end

      // ----------------------------------------------------------------
      // Avalon-MM slave: writes in one cycle, reads with one wait state.
      // ----------------------------------------------------------------
      s_nxt.rd_pend = 1'b0;
      s_nxt.rd_mem  = 1'b0;
      // Latch the result word so that read data stand until the next read.
      if (s_r.rd_mem) begin
         s_nxt.rdata = mem_rdata;
      end
      if (AVS_REQ.write) begin
         case (AVS_REQ.address)
            `FPT_OFF_DUTY0, `FPT_OFF_DUTY1, `FPT_OFF_DUTY2, `FPT_OFF_DUTY3: begin
               wv = fpt_lane({24'h0, s_r.duty[AVS_REQ.address[3:2]]}, AVS_REQ.writedata, AVS_REQ.byteenable);
               s_nxt.duty[AVS_REQ.address[3:2]] = fpt_clamp(wv[7:0]);
               duty_wr = 1'b1;
            end
            `FPT_OFF_CFG: begin
               wv = fpt_lane({16'h0, s_r.ppr, s_r.fs_en, s_r.rep_en}, AVS_REQ.writedata, AVS_REQ.byteenable);
               s_nxt.rep_en = wv[`FPT_CFG_REP_LSB +: NFAN];
               s_nxt.fs_en  = wv[`FPT_CFG_FS_LSB +: NFAN];
               s_nxt.ppr    = wv[`FPT_CFG_PPR_LSB +: 2*NFAN];
            end
            `FPT_OFF_GLITCH: begin
               wv = fpt_lane({16'h0, s_r.glitch}, AVS_REQ.writedata, AVS_REQ.byteenable);
               s_nxt.glitch = wv[15:0];
            end
            `FPT_OFF_FSTIME: begin
               s_nxt.fs_time = fpt_lane(s_r.fs_time, AVS_REQ.writedata, AVS_REQ.byteenable);
            end
            `FPT_OFF_IRQ_EN: begin
               wv = fpt_lane({28'h0, s_r.irq_en}, AVS_REQ.writedata, AVS_REQ.byteenable);
               s_nxt.irq_en = wv[NFAN-1:0];
            end
            `FPT_OFF_IRQ_CLR: begin
               // A report arriving in the same cycle keeps its bit set.
               s_nxt.irq_stat = s_nxt.irq_stat & ~(s_r.irq_stat & AVS_REQ.writedata[NFAN-1:0]);
               if (res_wr && s_r.rep_en[s_r.fan]) begin
                  s_nxt.irq_stat[s_r.fan] = 1'b1;
               end
            end
            `FPT_OFF_BOOT: begin
               s_nxt.boot = fpt_lane(s_r.boot, AVS_REQ.writedata, AVS_REQ.byteenable);
            end
            default: begin
            end
         endcase
      end
      if (duty_wr) begin
         s_nxt.fs_cnt  = '0;
         s_nxt.fs_trip = '0;
      end

      if (AVS_REQ.read && !s_r.rd_pend) begin
         s_nxt.rd_pend = 1'b1;
         s_nxt.rd_mem  = (AVS_REQ.address[7:4] == 4'h2);
         case (AVS_REQ.address)
            `FPT_OFF_DUTY0, `FPT_OFF_DUTY1, `FPT_OFF_DUTY2, `FPT_OFF_DUTY3:
               s_nxt.rdata = {24'h0, s_r.duty[AVS_REQ.address[3:2]]};
            `FPT_OFF_CFG:      s_nxt.rdata = {16'h0, s_r.ppr, s_r.fs_en, s_r.rep_en};
            `FPT_OFF_GLITCH:   s_nxt.rdata = {16'h0, s_r.glitch};
            `FPT_OFF_FSTIME:   s_nxt.rdata = s_r.fs_time;
            `FPT_OFF_IRQ_STAT: s_nxt.rdata = {28'h0, s_r.irq_stat};
            `FPT_OFF_IRQ_EN:   s_nxt.rdata = {28'h0, s_r.irq_en};
            `FPT_OFF_BOOT:     s_nxt.rdata = s_r.boot;
            default:           s_nxt.rdata = `FPT_BAD_READ;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_r          <= '0;
         s_r.duty     <= {NFAN{`FPT_DUTY_FULL}};
         s_r.glitch   <= `FPT_GLITCH_RST;
         s_r.fs_time  <= `FPT_FSTIME_RST;
         s_r.meas     <= FPT_ST_RUN;
         s_r.init     <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Fan channels
   // ----------------------------------------------------------------
   assign mem_raddr = AVS_REQ.address[3:2];

   fpt_result_mem #(
      .DEPTH (NFAN),
      .WIDTH (32)
   ) u_mem (
      .REF_CLK (REF_CLK),
      .RST_B   (RST_B),
      .WR_EN   (res_wr),
      .WR_ADDR (s_r.fan),
      .WR_DATA (res_wdata),
      .RD_ADDR (mem_raddr),
      .RD_DATA (mem_rdata)
   );

   genvar g;
   generate
      for (g = 0; g < NFAN; g++) begin : g_fan
         assign force_on[g] = s_r.rep_en[g] && (s_r.fan == FW'(g)) && (s_r.meas == FPT_ST_WIN)
                              && (s_r.edges != 2'b10);
         assign eff_duty[g] = s_r.fs_trip[g] ? `FPT_DUTY_FULL : s_r.duty[g];
         fpt_pwm u_pwm (
            .REF_CLK  (REF_CLK),
            .RST_B    (RST_B),
            .PHASE    (s_r.phase),
            .DUTY     (eff_duty[g]),
            .FORCE_ON (force_on[g]),
            .ENABLE   (s_r.started[g]),
            .SW_OE    (FAN_SW_OE[g])
         );
      end
   endgenerate

   // Open-drain low side: the switch only ever pulls to ground.
   assign FAN_SW_O            = '0;
   assign AVS_RSP.waitrequest = (AVS_REQ.read && !s_r.rd_pend);
   assign AVS_RSP.readdata    = s_r.rd_mem ? mem_rdata : s_r.rdata;
   assign IRQ                 = |(s_r.irq_stat & s_r.irq_en);
endmodule // fpt_top

// File: dv/fpt_top_monitor.sv
// Port checker for the fan controller.
`timescale 1ns/100ps
`include "fpt_map.svh"
module fpt_top_monitor #(
   parameter int NFAN    = 4,
   parameter int WIN_CYC = `FPT_WIN_CYC,
   parameter int GAP_CYC = `FPT_GAP_CYC
) (
   input wire logic              REF_CLK,
   input wire logic              RST_B,
   input wire fpt_pkg::fpt_req_t AVS_REQ,
   input wire fpt_pkg::fpt_rsp_t AVS_RSP,
   input wire logic [NFAN-1:0]   FAN_TACH,
   input wire logic [NFAN-1:0]   BOOT_VALID,
   input wire logic [NFAN-1:0]   FAN_SW_O,
   input wire logic [NFAN-1:0]   FAN_SW_OE,
   input wire logic              IRQ
);
   import fpt_pkg::*;
   logic [31:0]     rel_r;
   logic [NFAN-1:0] early;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rel_r <= 32'h0;
      end else if (rel_r != 32'hffff_ffff) begin
         rel_r <= rel_r + 32'h1;
      end
   end
   // A fan switched on before its slot would stack start-up currents.
   always_comb begin
      for (int i = 0; i < NFAN; i++) begin
         early[i] = rel_r < 32'(i * GAP_CYC);
      end
   end
   property p_od_low; FAN_SW_O == '0; endproperty
   a_od_low: assert property (p_od_low) else $error("switch pin driven high");
   property p_seq_gap; (FAN_SW_OE & early) == '0; endproperty
   a_seq_gap: assert property (p_seq_gap) else $error("fan started early");
   property p_rst_off; $rose(RST_B) |-> FAN_SW_OE == '0; endproperty
   a_rst_off: assert property (p_rst_off) else $error("switch on at reset release");
   property p_wr_nowait; AVS_REQ.write |-> !AVS_RSP.waitrequest; endproperty
   a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
   property p_rd_wait; $rose(AVS_REQ.read) |-> AVS_RSP.waitrequest ##1 !AVS_RSP.waitrequest; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read answer timing");
   property p_rd_hold; !AVS_REQ.read |-> $stable(AVS_RSP.readdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_bad_rd; AVS_REQ.read && !AVS_RSP.waitrequest && AVS_REQ.address == 8'h1c
      |-> AVS_RSP.readdata == `FPT_BAD_READ; endproperty
   a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
   property p_irq_early; rel_r < WIN_CYC |-> !IRQ; endproperty
   a_irq_early: assert property (p_irq_early) else $error("report before first window");
endmodule // fpt_top_monitor
bind fpt_top fpt_top_monitor #(.NFAN(NFAN), .WIN_CYC(WIN_CYC), .GAP_CYC(GAP_CYC)) i_fpt_top_monitor (
   .REF_CLK(REF_CLK), .RST_B(RST_B), .AVS_REQ(AVS_REQ), .AVS_RSP(AVS_RSP), .FAN_TACH(FAN_TACH),
   .BOOT_VALID(BOOT_VALID), .FAN_SW_O(FAN_SW_O), .FAN_SW_OE(FAN_SW_OE), .IRQ(IRQ));

// File: dv/fpt_fan_model.sv
// Behavioural three-pin fan whose tach toggles while powered.
`timescale 1ns/100ps
module fpt_fan_model #(
   parameter int HALF = 4
) (
   input  wire logic REF_CLK,
   input  wire logic RST_B,
   input  wire logic POWER_ON,
   output logic      TACH
);
   int ph;
   // An unpowered rotor stops, and the pull-up then holds the tach line high.
   always @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B || !POWER_ON) begin
         ph <= 0;
         TACH <= 1'b1;
      end else if (ph == HALF - 1) begin
         ph <= 0;
         TACH <= ~TACH;
      end else begin
         ph <= ph + 1;
      end
   end
endmodule // fpt_fan_model

// File: dv/fpt_top_test.sv
// Self-checking bench for the fan controller.
`timescale 1ns/100ps
`include "fpt_map.svh"
module fpt_top_test;
   import fpt_pkg::*;
   localparam int WIN = 200;
   localparam int GAP = 1000;
   logic        ref_clk;
   logic        rst_b;
   fpt_req_t    req;
   fpt_rsp_t    rsp;
   logic [3:0]  tach;
   logic [3:0]  boot_valid;
   logic [3:0]  sw_o;
   logic [3:0]  sw_oe;
   logic        irq;
   logic [31:0] rd;
   int          miscompares;
   int          cmp_count;
   int          cyc_n;
   int          t_on[4];
   int          len;

   fpt_top #(.NFAN(4), .WIN_CYC(WIN), .GAP_CYC(GAP)) i_fpt_top (
      .REF_CLK(ref_clk), .RST_B(rst_b), .AVS_REQ(req), .AVS_RSP(rsp), .FAN_TACH(tach),
      .BOOT_VALID(boot_valid), .FAN_SW_O(sw_o), .FAN_SW_OE(sw_oe), .IRQ(irq));
   for (genvar g = 0; g < 4; g++) begin : g_fan
      fpt_fan_model #(.HALF(4 + 2 * g)) i_fpt_fan_model (
         .REF_CLK(ref_clk), .RST_B(rst_b), .POWER_ON(sw_oe[g]), .TACH(tach[g]));
   end

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc_n++;
      for (int i = 0; i < 4; i++) begin
         if (sw_oe[i] === 1'b1 && t_on[i] == 0) begin
            t_on[i] = cyc_n;
         end
      end
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rng(input string what, input int lo, input int hi, input logic [31:0] got);
      cmp_count++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         miscompares++;
         $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   // The request holds until waitrequest is sampled low at a rising edge.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      req <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hf};
      do begin
         @(posedge ref_clk);
         n++;
      end while (rsp.waitrequest !== 1'b0 && n < 40);
      rd = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      if (n >= 40) begin
         check("bus answer", 32'h0, 32'h1);
         print_verdict();
      end
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(what, exp, rd);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic pulse(input int f);
      int n;
      n = 0;
      len = 0;
      while (sw_oe[f] !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      while (sw_oe[f] === 1'b1 && len < 400) begin
         @(posedge ref_clk);
         len++;
      end
      if (n >= 3000) begin
         check("forced pulse", 32'h1, 32'h0);
         print_verdict();
      end
   endtask

   initial begin
      rst_b = 1'b0;
      req = '0;
      boot_valid = 4'h0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rdc("boot level", 8'(4 * i), 32'h64);
      end
      cyc(3 * GAP + 50);
      for (int i = 1; i < 4; i++) begin
         check("start gap", 32'(i * GAP), 32'(t_on[i] - t_on[0]));
      end
      xfer(1'b1, `FPT_OFF_DUTY2, 32'hc8);
      rdc("clamped level", `FPT_OFF_DUTY2, 32'h64);
      xfer(1'b1, 8'h40, 32'hffff_ffff);
      rdc("unmapped", 8'h1c, `FPT_BAD_READ);
      xfer(1'b1, `FPT_OFF_CFG, 32'h0);
      xfer(1'b1, `FPT_OFF_DUTY1, 32'h0);
      cyc(20);
      len = 0;
      repeat (GAP + 50) begin
         @(posedge ref_clk);
         len += int'(sw_oe[1] !== 1'b0);
      end
      check("zero level on time", 32'h0, 32'(len));
      xfer(1'b1, `FPT_OFF_CFG, 32'h2);
      pulse(1);
      rng("stretch two edges", 10, 60, 32'(len));
      xfer(1'b1, `FPT_OFF_GLITCH, 32'd300);
      pulse(1);
      rng("stretch limit", WIN - 4, WIN, 32'(len));
      xfer(1'b1, `FPT_OFF_GLITCH, 32'h0);
      xfer(1'b1, `FPT_OFF_CFG, 32'h0000_e405);
      xfer(1'b1, `FPT_OFF_IRQ_EN, 32'h0);
      xfer(1'b1, `FPT_OFF_IRQ_CLR, 32'hf);
      cyc(GAP + 100);
      rdc("report status", `FPT_OFF_IRQ_STAT, 32'h5);
      check("masked irq", 32'h0, 32'(irq));
      xfer(1'b1, `FPT_OFF_IRQ_EN, 32'h1);
      cyc(2);
      check("enabled irq", 32'h1, 32'(irq));
      xfer(1'b1, `FPT_OFF_IRQ_CLR, 32'h1);
      cyc(2);
      check("cleared irq", 32'h0, 32'(irq));
      for (int i = 0; i < 4; i += 2) begin
         xfer(1'b0, 8'(`FPT_OFF_TACH0 + 4 * i), 32'h0);
         check("pulses per rev", 32'(i), {30'h0, rd[25:24]});
         rng("tach count", WIN / (8 + 4 * i) - 2, WIN / (8 + 4 * i) + 2, {8'h0, rd[23:0]});
      end
      xfer(1'b1, `FPT_OFF_CFG, 32'h10);
      xfer(1'b1, `FPT_OFF_FSTIME, 32'd600);
      xfer(1'b1, `FPT_OFF_DUTY0, 32'h0);
      cyc(400);
      xfer(1'b1, `FPT_OFF_DUTY0, 32'h0);
      cyc(400);
      check("restarted timeout", 32'h0, 32'(sw_oe[0]));
      cyc(250);
      check("fail-safe power", 32'h1, 32'(sw_oe[0]));
      check("no fail-safe", 32'h0, 32'(sw_oe[1]));
      print_verdict();
   end
endmodule // fpt_top_test
